/* hw/rsi_pkg.sv */
package rsi_pkg;

  localparam int RSI_NREG = 44;
  localparam int RSI_NRAM = 16;

  typedef enum logic [5:0] {
    R_PSW        = 6'h00, R_NVWC       = 6'h01, R_PORT_LATCH = 6'h02,
    R_PORT_DIR   = 6'h03, R_PULLUP     = 6'h04, R_CPU_CLK    = 6'h05,
    R_OSC_SEL    = 6'h06, R_T16A_CNT   = 6'h07, R_T16A_CCA   = 6'h08,
    R_T16A_CCB   = 6'h09, R_T16A_PRE   = 6'h0A, R_T16A_MODE  = 6'h0B,
    R_T16A_OUT   = 6'h0C, R_T16B_CNT   = 6'h0D, R_T16B_CMP   = 6'h0E,
    R_T16B_MODE  = 6'h0F, R_T8A_CNT    = 6'h10, R_T8A_CMP    = 6'h11,
    R_T8A_CLK    = 6'h12, R_T8A_MODE   = 6'h13, R_T8B_CNT    = 6'h14,
    R_T8B_CMP    = 6'h15, R_T8B_MODE   = 6'h16, R_WDT_CLK    = 6'h17,
    R_WDT_MODE   = 6'h18, R_SER_SYNC   = 6'h19, R_SER_ASYNC  = 6'h1A,
    R_SER_STAT   = 6'h1B, R_BAUD       = 6'h1C, R_TX_SHIFT   = 6'h1D,
    R_RX_BUF     = 6'h1E, R_POWER_ON_CLEAR_FLAG       = 6'h1F, R_LV_FLAG    = 6'h20,
    R_LV_LEVEL   = 6'h21, R_BB_LOW     = 6'h22, R_BB_HIGH    = 6'h23,
    R_BB_OUT     = 6'h24, R_KEY_EDGE   = 6'h25, R_INT_REQ    = 6'h26,
    R_INT_MASK   = 6'h27, R_EXT_INT    = 6'h28, R_STACK_PTR  = 6'h29,
    R_CAUSE      = 6'h2A, R_STATUS     = 6'h2B
  } rsi_reg_e;

  // index 0 first
  localparam logic [15:0] RSI_RST_VAL [RSI_NREG] = '{
    16'h0002, 16'h0008, 16'h0000, 16'h00FF, 16'h0000, 16'h0002,
    16'h0004, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h00FF,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h00FF, 16'h0000, 16'h0000,
    16'h0000, 16'h0000
  };

  // registers left untouched by a reset (contents undefined)
  localparam logic [RSI_NREG-1:0] RSI_NORESET  = 44'h20C_4020_0000;
  // 16-bit registers; all others are 8 bits wide
  localparam logic [RSI_NREG-1:0] RSI_WIDE     = 44'h000_0000_6380;
  // written by hardware only
  localparam logic [RSI_NREG-1:0] RSI_READONLY = 44'hC00_0000_0000;

  localparam int          RSI_NVWC_WEM_BIT   = 7;
  localparam logic [15:0] RSI_POWER_ON_CLEAR_FLAG_AFTER_POC = 16'h0004;
  localparam logic [6:0]  RSI_KEY_EDGE_HIGH  = 7'h40;
  localparam logic [15:0] RSI_VEC_LO_ADDR    = 16'h0000;
  localparam logic [15:0] RSI_VEC_HI_ADDR    = 16'h0001;

  localparam int RSI_CAUSE_EXT = 0;
  localparam int RSI_CAUSE_WDT = 1;
  localparam int RSI_CAUSE_POC = 2;
  localparam int RSI_CAUSE_KEY = 3;

  localparam logic [8:0] RSI_RAM_BASE = 9'h100;

  localparam int RSI_CLK_PERIOD_NS = 25;
  localparam int RSI_EXT_MIN_US    = 10;
  localparam int RSI_EXT_MIN_CYC   =
    (RSI_EXT_MIN_US * 1000 + RSI_CLK_PERIOD_NS - 1) / RSI_CLK_PERIOD_NS;
  localparam int RSI_SETTLE_CYC    = 1024;

  typedef enum logic [2:0] {
    ST_HOLD     = 3'b000,
    ST_SETTLE   = 3'b001,
    ST_FETCH_LO = 3'b010,
    ST_FETCH_HI = 3'b011,
    ST_RUN      = 3'b100
  } rsi_state_e;

endpackage : rsi_pkg

/* hw/rsi_src_if.sv */
interface rsi_src_if;
  logic       active;
  logic [3:0] cause;

  modport drive (output active, output cause);
  modport take  (input  active, input  cause);
endinterface : rsi_src_if

/* hw/rsi_sync.sv */
module rsi_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);
  logic [WIDTH-1:0] stage1;

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1 <= RST_VAL;
      q      <= RST_VAL;
    end else begin
      stage1 <= d;
      q      <= stage1;
    end
  end
endmodule : rsi_sync

/* hw/rsi_source.sv */
module rsi_source
  import rsi_pkg::*;
#(
  parameter int EXT_MIN_CYC = RSI_EXT_MIN_CYC
) (
  input  wire logic  mclk,
  input  wire logic  reset,
  input  wire logic  ext_reset_n_s,
  input  wire logic  poc_detect_s,
  input  wire logic  key_reset_enable_n_s,
  input  wire logic  wdt_overflow,
  input  wire logic  key_edge,
  input  wire logic  stop_mode,
  rsi_src_if.drive   src
);
  localparam int CW = $clog2(EXT_MIN_CYC + 1);

  logic [CW-1:0] ext_cnt;
  logic          ext_seen;
  logic          wdt_p;
  logic          key_p;
  logic [3:0]    now_bits;

  // short low glitches on the pin are not taken as a reset
  assign ext_seen = (ext_cnt == CW'(EXT_MIN_CYC)); // [RQ1]

  always_ff @(posedge mclk) begin
    if (reset || ext_reset_n_s) begin
      ext_cnt <= '0;
    end else if (!ext_seen) begin
      ext_cnt <= ext_cnt + CW'(1);
    end
  end

  // internal sources are pulses; they release on their own
  always_ff @(posedge mclk) begin
    if (reset) begin
      wdt_p <= 1'b0;
      key_p <= 1'b0;
    end else begin
      wdt_p <= wdt_overflow;
      key_p <= key_edge && !key_reset_enable_n_s && stop_mode; // [RQ22]
    end
  end

  assign now_bits = {key_p, poc_detect_s, wdt_p, ext_seen};

  always_ff @(posedge mclk) begin
    if (reset) begin
      src.active <= 1'b0;
      src.cause  <= 4'h0;
    end else begin
      src.active <= |now_bits; // [RQ22]
      if (|now_bits) begin
        // a new reset forgets the previous cause
        src.cause <= (src.active ? src.cause : 4'h0) | now_bits; // [RQ24]
      end
    end
  end
endmodule : rsi_source

/* hw/rsi_reset_state_initializer.sv */
// What this block does
// [RQ1] external reset pin must stay low at least 10 us to count
// [RQ2] reset from stop mode keeps stop conditions while reset is held
// [RQ3] all port pins float while reset or settling is in progress
// [RQ4] program counter is loaded from vector bytes at 0000H and 0001H
// [RQ5] program counter invalid during reset and settle; others already reset
// [RQ6] stack pointer untouched; status word becomes 02H
// [RQ7] nonvolatile write control becomes 08H, bit 7 follows enable pin
// [RQ8] data RAM and general registers keep contents over reset
// [RQ9] port latches 00H, direction FFH, pull-up options 00H
// [RQ10] cpu clock control 02H, oscillator settle select 04H
// [RQ11] first 16-bit timer: counter, captures 0000H, controls 00H
// [RQ12] second 16-bit timer: counter, compare 0000H, mode 00H
// [RQ13] first 8-bit timer: all four registers 00H
// [RQ14] second 8-bit timer: counter, mode 00H, compare untouched
// [RQ15] watchdog clock select and mode become 00H
// [RQ16] serial controls 00H, transmit shift FFH, receive buffer untouched
// [RQ17] power-on-clear flag 04H after power-on-clear reset, else 00H
// [RQ18] low-voltage flag and level select become 00H
// [RQ19] bit buffer data untouched, its output control 00H
// [RQ20] key edge register 1000000xB after key reset without power-on-clear, else 00H
// [RQ21] request flags 00H, masks FFH, external interrupt mode 00H
// [RQ22] four reset sources merge into one reset
// [RQ23] every source has the same effect; run starts from the vector
// [RQ24] reset cause is latched to pick source-dependent values
module rsi_reset_state_initializer
  import rsi_pkg::*;
#(
  parameter int SETTLE_CYCLES = RSI_SETTLE_CYC,
  parameter int EXT_MIN_CYC   = RSI_EXT_MIN_CYC
) (
  input  wire logic                      mclk,
  input  wire logic                      reset,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [8:0]                wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      reset_n_pin,
  input  wire logic                      poc_detect,
  input  wire logic                      key_reset_enable_pin_n,
  input  wire logic                      nv_write_enable_pin,
  input  wire logic                      wdt_overflow,
  input  wire logic                      key_edge,
  input  wire logic                      stop_mode,
  output logic      [15:0]               vec_addr,
  input  wire logic [7:0]                vec_data,
  output logic      [15:0]               program_counter,
  output logic                           pc_valid,
  output logic                           core_reset,
  output logic                           stop_hold,
  output logic      [7:0]                port_out,
  output logic      [7:0]                port_oe,
  output logic      [RSI_NREG-1:0][15:0] periph_regs
);
  localparam int SW = $clog2(SETTLE_CYCLES + 1);

  rsi_src_if src_bus ();

  logic [3:0]  pins_s;
  logic        ext_reset_n_s;
  logic        poc_detect_s;
  logic        key_reset_enable_n_s;
  logic        nv_write_enable_s;

  rsi_state_e  state;
  logic [SW-1:0] settle_cnt;
  logic        init_now;
  logic        run_next;

  logic [7:0]  ram [RSI_NRAM];
  logic        wb_req;
  logic        wr_en;
  logic [5:0]  wb_idx;
  logic [3:0]  ram_idx;
  logic        reg_hit;
  logic        ram_hit;
  logic [15:0] rd_reg;

  rsi_sync #(
    .WIDTH   (4),
    .RST_VAL (4'b0101)
  ) u_pin_sync (
    .mclk  (mclk),
    .reset (reset),
    .d     ({nv_write_enable_pin, key_reset_enable_pin_n,
             poc_detect, reset_n_pin}),
    .q     (pins_s)
  );

  assign ext_reset_n_s        = pins_s[0];
  assign poc_detect_s         = pins_s[1];
  assign key_reset_enable_n_s = pins_s[2];
  assign nv_write_enable_s    = pins_s[3];

  rsi_source #(
    .EXT_MIN_CYC (EXT_MIN_CYC)
  ) u_source (
    .mclk                 (mclk),
    .reset                (reset),
    .ext_reset_n_s        (ext_reset_n_s),
    .poc_detect_s         (poc_detect_s),
    .key_reset_enable_n_s (key_reset_enable_n_s),
    .wdt_overflow         (wdt_overflow),
    .key_edge             (key_edge),
    .stop_mode            (stop_mode),
    .src                  (src_bus.drive)
  );

  // the peripheral registers sit in their reset state until the core runs
  assign init_now = reset || src_bus.active || (state != ST_RUN); // [RQ5]
  assign run_next = !src_bus.active &&
                    (state == ST_FETCH_HI || state == ST_RUN);

  // one sequence for every source, so all resets look alike
  always_ff @(posedge mclk) begin
    if (reset || src_bus.active) begin
      state      <= ST_HOLD; // [RQ23]
      settle_cnt <= '0;
    end else begin
      unique case (state)
        ST_HOLD: begin
          state      <= ST_SETTLE;
          settle_cnt <= '0;
        end
        ST_SETTLE: begin
          if (settle_cnt == SW'(SETTLE_CYCLES - 1)) begin
            state <= ST_FETCH_LO;
          end else begin
            settle_cnt <= settle_cnt + SW'(1);
          end
        end
        ST_FETCH_LO: state <= ST_FETCH_HI;
        ST_FETCH_HI: state <= ST_RUN;
        ST_RUN:      state <= ST_RUN;
        default:     state <= ST_HOLD;
      endcase
    end
  end

  // vector fetch: address leads, data is taken one cycle later
  always_ff @(posedge mclk) begin
    if (reset || src_bus.active || state == ST_HOLD) begin
      vec_addr        <= RSI_VEC_LO_ADDR; // [RQ4]
      program_counter <= 16'h0000;
      pc_valid        <= 1'b0; // [RQ5]
    end else begin
      unique case (state)
        ST_FETCH_LO: begin
          program_counter[7:0] <= vec_data; // [RQ4]
          vec_addr             <= RSI_VEC_HI_ADDR;
        end
        ST_FETCH_HI: begin
          program_counter[15:8] <= vec_data; // [RQ4]
          pc_valid              <= 1'b1; // [RQ23]
        end
        default: begin
          vec_addr <= vec_addr;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= !run_next;
    end
  end

  // stop conditions survive only while the reset is actually applied
  always_ff @(posedge mclk) begin
    if (reset) begin
      stop_hold <= 1'b0;
    end else begin
      stop_hold <= src_bus.active && (stop_hold || stop_mode); // [RQ2]
    end
  end

  // pins float until the core runs, whatever direction is set
  always_ff @(posedge mclk) begin
    if (reset) begin
      port_out <= 8'h00;
      port_oe  <= 8'h00;
    end else begin
      port_out <= periph_regs[R_PORT_LATCH][7:0];
      port_oe  <= run_next ? ~periph_regs[R_PORT_DIR][7:0]
                           : 8'h00; // [RQ3]
    end
  end

  // peripheral register file: reset values, source specials, writes
  always_ff @(posedge mclk) begin
    for (int i = 0; i < RSI_NREG; i++) begin
      if (init_now) begin
        // table covers status word, ports, clocks, timers, watchdog,
        // serial, supply monitor, bit buffer and interrupt registers
        if (!RSI_NORESET[i]) begin
          periph_regs[i] <= RSI_RST_VAL[i]; // [RQ6] [RQ9] [RQ10] [RQ11]
        end
        // undefined ones are simply not touched
        // [RQ14] [RQ16] [RQ19] [RQ6]
      end else if (wr_en && reg_hit && wb_idx == 6'(i) &&
                   !RSI_READONLY[i]) begin
        if (wb_sel_i[0]) begin
          periph_regs[i][7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1] && RSI_WIDE[i]) begin
          periph_regs[i][15:8] <= wb_dat_i[15:8];
        end
      end
    end
    if (init_now) begin
      // timer, watchdog and serial reset values share the table above
      // [RQ12] [RQ13] [RQ15] [RQ18] [RQ21]
      periph_regs[R_NVWC][RSI_NVWC_WEM_BIT] <= nv_write_enable_s; // [RQ7]
      if (src_bus.cause[RSI_CAUSE_POC]) begin
        periph_regs[R_POWER_ON_CLEAR_FLAG] <= RSI_POWER_ON_CLEAR_FLAG_AFTER_POC; // [RQ17]
      end else begin
        periph_regs[R_POWER_ON_CLEAR_FLAG] <= 16'h0000; // [RQ17]
      end
      if (src_bus.cause[RSI_CAUSE_KEY] && !src_bus.cause[RSI_CAUSE_POC])
      begin
        periph_regs[R_KEY_EDGE] <= {8'h00, RSI_KEY_EDGE_HIGH,
                                    periph_regs[R_KEY_EDGE][0]}; // [RQ20]
      end else begin
        periph_regs[R_KEY_EDGE] <= 16'h0000; // [RQ20]
      end
    end
    periph_regs[R_CAUSE]  <= {12'h000, src_bus.cause}; // [RQ24]
    periph_regs[R_STATUS] <= {11'h000, pc_valid, stop_hold, state};
  end

  // no reset reaches data RAM: contents ride through any reset
  always_ff @(posedge mclk) begin
    if (wr_en && ram_hit && wb_sel_i[0]) begin
      ram[ram_idx] <= wb_dat_i[7:0]; // [RQ8]
    end
  end

  // wishbone slave, answers every access one cycle after the request
  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en   = wb_req && wb_we_i;
  assign wb_idx  = wb_adr_i[7:2];
  assign ram_idx = wb_adr_i[5:2];
  assign reg_hit = !wb_adr_i[8] && (wb_idx < 6'(RSI_NREG));
  assign ram_hit = (wb_adr_i[8:6] == RSI_RAM_BASE[8:6]);
  assign rd_reg  = RSI_WIDE[wb_idx] ? periph_regs[wb_idx]
                                    : {8'h00, periph_regs[wb_idx][7:0]};

  always_ff @(posedge mclk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        if (reg_hit) begin
          wb_dat_o <= {16'h0000, rd_reg};
        end else if (ram_hit) begin
          wb_dat_o <= {24'h00_0000, ram[ram_idx]};
        end else begin
          wb_dat_o <= 32'h0000_0000;
        end
      end
    end
  end

endmodule : rsi_reset_state_initializer

/* bench/rsi_ext_rst_model.sv */
module rsi_ext_rst_model (
  input  wire logic        mclk,
  input  wire logic        go,
  input  wire logic [15:0] hold_cyc,
  output logic             reset_n_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  int left = 0;
  // low for exactly hold_cyc edges; short pulses test the refusal
  always @(posedge mclk) begin
    if (go)
      left <= hold_cyc;
    else if (left > 0)
      left <= left - 1;
  end
  // pull-up holds the pin high between pulses
  assign reset_n_pin = (left == 0);
endmodule : rsi_ext_rst_model

/* bench/rsi_chk_asserts.sv */
module rsi_chk
  import rsi_pkg::*;
(
  input wire logic                      mclk,
  input wire logic                      reset,
  input wire logic                      wdt_overflow,
  input wire logic                      core_reset,
  input wire logic                      pc_valid,
  input wire logic                      stop_hold,
  input wire logic [15:0]               vec_addr,
  input wire logic [7:0]                port_oe,
  input wire logic [RSI_NREG-1:0][15:0] periph_regs
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // one edge of slack: regs init on the same edge that core_reset rises
  sequence held_rst;
    core_reset && $past(core_reset);
  endsequence
  chk_oe_float: assert property (core_reset |-> port_oe == 8'h00)
    else $error("port driven during reset");
  chk_regs_init: assert property (held_rst |->
    periph_regs[R_PSW] == 16'h0002 && periph_regs[R_PORT_DIR] == 16'h00FF
    && periph_regs[R_CPU_CLK] == 16'h0002 && periph_regs[R_OSC_SEL] ==
    16'h0004 && periph_regs[R_TX_SHIFT] == 16'h00FF
    && periph_regs[R_INT_MASK] == 16'h00FF)
    else $error("core regs not at init value");
  chk_timer_clear: assert property (held_rst |->
    periph_regs[R_T16A_CNT] == 16'h0000 && periph_regs[R_T16B_CMP] ==
    16'h0000 && periph_regs[R_T8A_CMP] == 16'h0000
    && periph_regs[R_T8B_CNT] == 16'h0000 && periph_regs[R_WDT_MODE] ==
    16'h0000 && periph_regs[R_LV_LEVEL] == 16'h0000
    && periph_regs[R_BB_OUT] == 16'h0000)
    else $error("timer regs not cleared");
  chk_nv_low: assert property (held_rst |->
    periph_regs[R_NVWC][6:0] == 7'h08) else $error("nv control low bits");
  chk_stop_hold: assert property (
    stop_hold |-> core_reset && !pc_valid)
    else $error("stop hold outside reset");
  chk_pc_undef: assert property (core_reset |-> !pc_valid)
    else $error("pc valid during reset");
  chk_fetch_order: assert property ($rose(pc_valid) |->
    $past(vec_addr) == RSI_VEC_HI_ADDR && !core_reset &&
    $past(vec_addr, 2) == RSI_VEC_LO_ADDR) else $error("vector fetch order");
  chk_wdt_merge: assert property (wdt_overflow |->
    ##[1:3] (core_reset && !pc_valid)) else $error("watchdog not merged");
  chk_oe_entry: assert property ($rose(pc_valid) |->
    port_oe == ~periph_regs[R_PORT_DIR][7:0]) else $error("oe at run");
  cover property ($rose(pc_valid));
  cover property ($rose(stop_hold));
  cover property (wdt_overflow);
endmodule : rsi_chk

bind rsi_reset_state_initializer rsi_chk u_chk (
  .mclk(mclk), .reset(reset), .wdt_overflow(wdt_overflow),
  .core_reset(core_reset), .pc_valid(pc_valid), .stop_hold(stop_hold),
  .vec_addr(vec_addr), .port_oe(port_oe), .periph_regs(periph_regs));

/* bench/rsi_reset_state_initializer_tb.sv */
module rsi_reset_state_initializer_tb
  import rsi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, go;
  logic        poc_detect, key_reset_enable_pin_n, nv_write_enable_pin;
  logic        wdt_overflow, key_edge, stop_mode, reset_n_pin, saw_hold;
  logic        pc_valid, core_reset, stop_hold, kb0;
  logic [8:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, d, ram;
  logic [15:0] vec_addr, program_counter, vec, hold_cyc;
  logic [7:0]  vec_data, port_out, port_oe;
  logic [RSI_NREG-1:0][15:0] periph_regs;
  logic [31:0] q[$];
  logic [31:0] held[RSI_NREG];
  int          miscompares, n_compared, seed, s;

  rsi_reset_state_initializer #(.SETTLE_CYCLES(4), .EXT_MIN_CYC(4)) uut (
    .mclk(mclk), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .reset_n_pin(reset_n_pin), .poc_detect(poc_detect),
    .key_reset_enable_pin_n(key_reset_enable_pin_n),
    .nv_write_enable_pin(nv_write_enable_pin), .wdt_overflow(wdt_overflow),
    .key_edge(key_edge), .stop_mode(stop_mode), .vec_addr(vec_addr),
    .vec_data(vec_data), .program_counter(program_counter),
    .pc_valid(pc_valid), .core_reset(core_reset), .stop_hold(stop_hold),
    .port_out(port_out), .port_oe(port_oe), .periph_regs(periph_regs));
  rsi_ext_rst_model u_ext (.mclk(mclk), .go(go), .hold_cyc(hold_cyc),
    .reset_n_pin(reset_n_pin));

  assign vec_data = vec_addr[0] ? vec[15:8] : vec[7:0];
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (n_compared > 0 && miscompares == 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] v);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= v;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50)
      miscompares++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge mclk);
  endtask : wb

  task automatic rd(input logic [8:0] a, input logic [31:0] exp);
    q.push_back(exp);
    wb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // reads checked at the ack edge, oldest note first
  always @(posedge mclk)
    if (wb_ack_o === 1'b1 && wb_cyc_i && !wb_we_i && q.size() > 0)
      check(wb_dat_o, q.pop_front());

  always @(posedge mclk)
    if (stop_hold === 1'b1)
      saw_hold <= 1'b1;

  function automatic logic [31:0] exp_rst(int i, logic pf, logic [1:0] k);
    case (i)
      0, 5:       return 32'h0000_0002;
      1:          return {24'h0, nv_write_enable_pin, 7'h08};
      3, 29, 39:  return 32'h0000_00FF;
      6:          return 32'h0000_0004;
      31:         return pf ? 32'h0000_0004 : 32'h0000_0000;
      37:         return k[1] ? {24'h0, 7'h40, k[0]} : 32'h0000_0000;
      default:    return 32'h0000_0000;
    endcase
  endfunction : exp_rst

  task automatic wait_run;
    int n;
    n = 0;
    while (pc_valid !== 1'b0 && n < 20) begin
      @(posedge mclk);
      n++;
    end
    while (pc_valid !== 1'b1 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 200)
      miscompares++;
    check(program_counter, vec);
    check({port_out, port_oe}, 16'h0000);
  endtask : wait_run

  task automatic check_all(input logic pf, input logic [1:0] k);
    for (int i = 0; i < 42; i++)
      if (i inside {21, 30, 34, 35, 41}) begin
        if (held[i] !== 'x)
          rd(9'(4 * i), held[i]);
      end else
        rd(9'(4 * i), exp_rst(i, pf, k));
  endtask : check_all

  initial begin
    seed = 32'h328c;
    {wb_cyc_i, wb_stb_i, wb_we_i, go, poc_detect, wdt_overflow} = '0;
    {key_edge, stop_mode, saw_hold, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {key_reset_enable_pin_n, nv_write_enable_pin, reset} = 3'b111;
    hold_cyc = 16'h0006;
    vec = 16'($random(seed));
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    wait_run;
    check_all(1'b0, 2'b00);
    hold_cyc <= 16'h0002;
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    repeat (12) @(posedge mclk);
    check({31'h0, pc_valid}, 32'h0000_0001);
    hold_cyc <= 16'h0006;
    for (s = 0; s < 4; s++) begin
      nv_write_enable_pin <= s[0];
      for (int i = 0; i < 42; i++) begin
        d = $random(seed);
        wb(1'b1, 9'(4 * i), d);
        held[i] = (i inside {21, 30, 34, 35, 41}) ? {24'h0, d[7:0]} : 'x;
        if (i == 37)
          kb0 = d[0];
      end
      ram = $random(seed);
      wb(1'b1, 9'h104, ram);
      vec <= 16'($random(seed));
      case (s)
        0: go <= 1'b1;
        1: wdt_overflow <= 1'b1;
        2: poc_detect <= 1'b1;
        default: begin
          stop_mode <= 1'b1;
          key_reset_enable_pin_n <= 1'b0;
          repeat (4) @(posedge mclk);
          key_edge <= 1'b1;
        end
      endcase
      @(posedge mclk);
      {go, wdt_overflow, key_edge} <= 3'b000;
      repeat (3) @(posedge mclk);
      poc_detect <= 1'b0;
      stop_mode <= 1'b0;
      key_reset_enable_pin_n <= 1'b1;
      wait_run;
      check_all(s == 2, {s == 3, kb0});
      rd(9'h104, {24'h0, ram[7:0]});
      rd(9'(4 * 42), 32'(1 << s));
    end
    check({31'h0, saw_hold}, 32'h0000_0001);
    print_verdict;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    print_verdict;
  end
endmodule : rsi_reset_state_initializer_tb
